//--- hw/psc_map.svh
// Register offsets, field positions and reset values of the PHY status/counter bank
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH
// Register indices; byte address is four times the index
`define PSC_IDX_INT_STATUS 8'h11
`define PSC_IDX_LINK_LOSS 8'h12
`define PSC_IDX_FALSE_CAR 8'h13
`define PSC_IDX_SCR_SEED 8'h14
`define PSC_IDX_RX_ERR 8'h15
`define PSC_IDX_IRQ_ENABLE 8'h20
`define PSC_IDX_IRQ_CLEAR 8'h21
`define PSC_IDX_CONFIG 8'h22
// Interrupt status bit positions
`define PSC_BIT_PAGE_RX 1
`define PSC_BIT_REMOTE_FAULT 2
`define PSC_BIT_RXERR_MSB 9
`define PSC_BIT_FCAR_MSB 10
`define PSC_BIT_LLOSS_MSB 11
// Scrambler seed fields
`define PSC_BIT_SEED_LOAD 15
`define PSC_SEED_KEY_W 11
// Config bits
`define PSC_BIT_CFG_ANEG 0
`define PSC_BIT_CFG_COMPAT 1
// Reset values and counter limits
`define PSC_RST_SEED 11'h000
`define PSC_RST_CONFIG 2'h1
`define PSC_CNT_MAX 16'hFFFF
`define PSC_CNT_ZERO 16'h0000
`endif

//--- hw/psc_pkg.sv
// Types shared by the PHY status/counter bank
`default_nettype none
package psc_pkg;
   // Raw event pins from the PHY datapath
   typedef struct packed {
      logic link_good;
      logic far_end_fault;
      logic false_carrier;
      logic rx_packet_active;
      logic rx_error;
      logic collision;
   } psc_evt_s;
   // Auto-negotiation word handoff
   typedef struct packed {
      logic word_valid;
      logic word_checked;
      logic remote_fault;
   } psc_aneg_s;
   // Scrambler seed output
   typedef struct packed {
      logic load;
      logic bypass;
      logic [10:0] key;
   } psc_scr_s;
   // Page-kind tracking
   typedef enum logic [0:0] {
      PSC_PG_BASE = 1'b0,
      PSC_PG_NEXT = 1'b1
   } psc_page_e;
endpackage
`default_nettype wire

//--- hw/psc_sync.sv
// Two-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module psc_sync #(
   parameter int W = 1
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } psc_sync_s;
   psc_sync_s st_ff;
   psc_sync_s nxt_st;
   // First stage feeds only the second
   always_comb begin
      nxt_st.s1 = async_in;
      nxt_st.s2 = st_ff.s1;
   end
   // Register both stages
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
   assign sync_out = st_ff.s2;
endmodule
`default_nettype wire

//--- hw/psc_counter.sv
// Clear-on-read 16-bit event counter, wrapping or saturating
`timescale 1ns/1ps
`default_nettype none
`include "psc_map.svh"
module psc_counter #(
   parameter bit SATURATE = 1'b0
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic inc,
   input wire logic rd_clr,
   output logic [15:0] count,
   output logic msb_rise
);
   typedef struct packed {
      logic [15:0] cnt;
   } psc_cnt_s;
   psc_cnt_s st_ff;
   psc_cnt_s nxt_st;
   logic [15:0] base;
   // Clear then add, so an event on the read cycle survives the clear
   always_comb begin
      base = rd_clr ? `PSC_CNT_ZERO : st_ff.cnt;
      nxt_st.cnt = base;
      if (inc) begin
         if (SATURATE && base == `PSC_CNT_MAX) begin
            nxt_st.cnt = base;
         end else begin
            nxt_st.cnt = base + 16'h0001;
         end
      end
   end
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
   assign count = st_ff.cnt;
   assign msb_rise = nxt_st.cnt[15] & ~st_ff.cnt[15];
endmodule
`default_nettype wire

//--- hw/psc_top.sv
// APB register bank: interrupt status, event counters, scrambler seed
`timescale 1ns/1ps
`default_nettype none
`include "psc_map.svh"
// Operation
// - Aneg on: partner remote fault sets bit 2
// - Aneg off: far-end fault sets bit 2
// - Checked aneg word sets self-clearing bit 1
// - First page base, later pages next
// - Link loss counter counts link-good losses
// - Link loss read clears; wraps to zero
// - False carrier counter counts bad delimiters
// - One increment per event, at its end
// - False carrier read clears; saturates FFFFh
// - Load bit loads key, then self-clears
// - All-zero key bypasses the scrambler
// - Compatibility mode blocks key writes
// - Receive error counts errored non-collision packets
// - Receive error read clears; wraps to zero
// - Counter MSB rising sets bits 11,10,9
module psc_top (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire psc_pkg::psc_evt_s evt_pins,
   input wire psc_pkg::psc_aneg_s aneg_in,
   output psc_pkg::psc_scr_s scr_out,
   output logic page_is_next,
   output logic irq
);
   // Whole block state
   typedef struct packed {
      logic [31:0] rdata;
      logic ready;
      logic slverr;
      logic [15:0] status;
      logic [15:0] irq_en;
      logic [1:0] cfg;
      logic [10:0] key;
      logic load;
      logic load_out;
      logic bypass;
      logic irq;
      logic link_good_d;
      logic fcar_d;
      logic pkt_d;
      logic pkt_err;
      logic pkt_col;
      logic pg_rx;
      psc_pkg::psc_page_e page;
      logic pg_seen; // A page already arrived in this exchange
   } psc_top_s;
   psc_top_s st_ff;
   psc_top_s nxt_st;
   psc_pkg::psc_evt_s evt_s;
   logic [5:0] evt_raw;
   logic [5:0] evt_sync;
   logic acc;
   logic [7:0] idx;
   logic rd_ll;
   logic rd_fc;
   logic rd_re;
   logic inc_ll;
   logic inc_fc;
   logic inc_re;
   logic [15:0] cnt_ll;
   logic [15:0] cnt_fc;
   logic [15:0] cnt_re;
   logic msb_ll;
   logic msb_fc;
   logic msb_re;
   logic page_evt;
   logic [15:0] set_bits;
   logic [15:0] clr_bits;

   // Word index decode, used for reads and writes alike
   function automatic logic [7:0] word_idx(input logic [11:0] a);
      word_idx = a[9:2];
   endfunction

   // Datapath pins come from another domain
   assign evt_raw = evt_pins;
   psc_sync #(.W(6)) u_sync (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .async_in(evt_raw),
      .sync_out(evt_sync)
   );
   assign evt_s = evt_sync;

   // Access phase, answered in one wait state so pready is a flop
   assign acc = psel & penable & ~st_ff.ready;
   assign idx = word_idx(paddr);
   assign rd_ll = acc & ~pwrite & (idx == `PSC_IDX_LINK_LOSS);
   assign rd_fc = acc & ~pwrite & (idx == `PSC_IDX_FALSE_CAR);
   assign rd_re = acc & ~pwrite & (idx == `PSC_IDX_RX_ERR);

   // Link-good falling edge counts one loss
   assign inc_ll = st_ff.link_good_d & ~evt_s.link_good;
   // False carrier counted at its trailing edge only
   assign inc_fc = st_ff.fcar_d & ~evt_s.false_carrier;
   // Packet end with an error seen and no collision
   assign inc_re = st_ff.pkt_d & ~evt_s.rx_packet_active & st_ff.pkt_err & ~st_ff.pkt_col;

   // Link loss: wraps
   psc_counter #(.SATURATE(1'b0)) u_ll (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .inc(inc_ll),
      .rd_clr(rd_ll),
      .count(cnt_ll),
      .msb_rise(msb_ll)
   );
   // False carrier: saturates
   psc_counter #(.SATURATE(1'b1)) u_fc (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .inc(inc_fc),
      .rd_clr(rd_fc),
      .count(cnt_fc),
      .msb_rise(msb_fc)
   );
   // Receive error: wraps
   psc_counter #(.SATURATE(1'b0)) u_re (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .inc(inc_re),
      .rd_clr(rd_re),
      .count(cnt_re),
      .msb_rise(msb_re)
   );

   // Checked auto-negotiation word arrives
   assign page_evt = aneg_in.word_valid & aneg_in.word_checked;

   // Hardware set sources for the sticky status bits
   always_comb begin
      set_bits = 16'h0000;
      if (st_ff.cfg[`PSC_BIT_CFG_ANEG]) begin
         set_bits[`PSC_BIT_REMOTE_FAULT] = page_evt & aneg_in.remote_fault;
      end else begin
         set_bits[`PSC_BIT_REMOTE_FAULT] = evt_s.far_end_fault;
      end
      set_bits[`PSC_BIT_LLOSS_MSB] = msb_ll;
      set_bits[`PSC_BIT_FCAR_MSB] = msb_fc;
      set_bits[`PSC_BIT_RXERR_MSB] = msb_re;
   end

   // Write-one-to-clear bits from the clear register
   assign clr_bits = (acc & pwrite & idx == `PSC_IDX_IRQ_CLEAR) ? pwdata[15:0] : 16'h0000;

   // Next-state logic for the bus slave and all control state
   always_comb begin
      nxt_st = st_ff;
      nxt_st.ready = acc;
      nxt_st.slverr = 1'b0;
      nxt_st.rdata = 32'h0000_0000;
      // Edge history of synchronised pins
      nxt_st.link_good_d = evt_s.link_good;
      nxt_st.fcar_d = evt_s.false_carrier;
      nxt_st.pkt_d = evt_s.rx_packet_active;
      // Error and collision flags gathered across a packet
      if (evt_s.rx_packet_active & ~st_ff.pkt_d) begin
         nxt_st.pkt_err = evt_s.rx_error;
         nxt_st.pkt_col = evt_s.collision;
      end else if (evt_s.rx_packet_active) begin
         nxt_st.pkt_err = st_ff.pkt_err | evt_s.rx_error;
         nxt_st.pkt_col = st_ff.pkt_col | evt_s.collision;
      end
      // Page received lasts one cycle; it is a pulse, not sticky
      nxt_st.pg_rx = page_evt;
      // First page of an exchange is base, the rest next
      if (page_evt) begin
         nxt_st.pg_seen = 1'b1;
         nxt_st.page = st_ff.pg_seen ? psc_pkg::PSC_PG_NEXT : psc_pkg::PSC_PG_BASE;
      end
      // A new exchange restarts whenever link is lost
      if (inc_ll) begin
         nxt_st.page = psc_pkg::PSC_PG_BASE;
         nxt_st.pg_seen = 1'b0;
      end
      // Load bit self-clears in the same cycle its one-cycle strobe reaches the scrambler
      nxt_st.load_out = st_ff.load;
      if (st_ff.load) begin
         nxt_st.load = 1'b0;
      end
      nxt_st.bypass = (st_ff.key == `PSC_RST_SEED);
      // Sticky status: set wins over clear
      nxt_st.status = (st_ff.status & ~clr_bits) | set_bits;
      nxt_st.status[`PSC_BIT_PAGE_RX] = 1'b0;
      nxt_st.status[0] = 1'b0;
      // Register writes
      if (acc & pwrite) begin
         case (idx)
            `PSC_IDX_SCR_SEED: begin
               // Bits 14:11 are dropped whatever software writes
               if (!st_ff.cfg[`PSC_BIT_CFG_COMPAT]) begin
                  nxt_st.key = pwdata[`PSC_SEED_KEY_W-1:0];
               end
               if (pwdata[`PSC_BIT_SEED_LOAD]) begin
                  nxt_st.load = 1'b1;
               end
            end
            `PSC_IDX_IRQ_ENABLE: begin
               nxt_st.irq_en = pwdata[15:0];
            end
            `PSC_IDX_CONFIG: begin
               nxt_st.cfg = pwdata[1:0];
            end
            `PSC_IDX_IRQ_CLEAR, `PSC_IDX_INT_STATUS, `PSC_IDX_LINK_LOSS,
            `PSC_IDX_FALSE_CAR, `PSC_IDX_RX_ERR: begin
               nxt_st.slverr = 1'b0;
            end
            default: begin
               nxt_st.slverr = 1'b1;
            end
         endcase
      end
      // Register reads
      if (acc & ~pwrite) begin
         case (idx)
            `PSC_IDX_INT_STATUS: begin
               nxt_st.rdata[15:0] = st_ff.status | {14'h0000, st_ff.pg_rx, 1'b0};
            end
            `PSC_IDX_LINK_LOSS: nxt_st.rdata[15:0] = cnt_ll;
            `PSC_IDX_FALSE_CAR: nxt_st.rdata[15:0] = cnt_fc;
            `PSC_IDX_SCR_SEED: begin
               nxt_st.rdata[15:0] = {st_ff.load, 4'h0, st_ff.key};
            end
            `PSC_IDX_RX_ERR: nxt_st.rdata[15:0] = cnt_re;
            `PSC_IDX_IRQ_ENABLE: nxt_st.rdata[15:0] = st_ff.irq_en;
            `PSC_IDX_CONFIG: nxt_st.rdata[1:0] = st_ff.cfg;
            `PSC_IDX_IRQ_CLEAR: nxt_st.rdata = 32'h0000_0000;
            default: nxt_st.slverr = 1'b1;
         endcase
      end
      // Level interrupt from enabled status bits
      nxt_st.irq = |(nxt_st.status & st_ff.irq_en) | (page_evt & st_ff.irq_en[`PSC_BIT_PAGE_RX]);
   end

   // Single state register
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_ff <= '0;
         st_ff.cfg <= `PSC_RST_CONFIG;
         st_ff.key <= `PSC_RST_SEED;
         st_ff.bypass <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Outputs straight from flops
   assign prdata = st_ff.rdata;
   assign pready = st_ff.ready;
   assign pslverr = st_ff.slverr;
   assign scr_out.load = st_ff.load_out;
   assign scr_out.bypass = st_ff.bypass;
   assign scr_out.key = st_ff.key;
   assign page_is_next = st_ff.page;
   assign irq = st_ff.irq;

   // Loss of link bumps the counter by one on the next cycle
   property p_ll_inc;
      @(posedge sys_clk) disable iff (sys_rst)
      (inc_ll & ~rd_ll & cnt_ll != `PSC_CNT_MAX) |=> (cnt_ll == $past(cnt_ll) + 16'h0001);
   endproperty
   a_ll_inc: assert property (p_ll_inc) else $error("link loss count did not step");

   property p_ll_clr;
      @(posedge sys_clk) disable iff (sys_rst)
      (rd_ll & ~inc_ll) |=> (cnt_ll == 16'h0000);
   endproperty
   a_ll_clr: assert property (p_ll_clr) else $error("link loss not cleared on read");

   property p_fc_sat;
      @(posedge sys_clk) disable iff (sys_rst)
      (cnt_fc == 16'hFFFF & ~rd_fc) |=> (cnt_fc == 16'hFFFF);
   endproperty
   a_fc_sat: assert property (p_fc_sat) else $error("false carrier count wrapped");

   property p_fc_end;
      @(posedge sys_clk) disable iff (sys_rst)
      (evt_s.false_carrier & ~rd_fc) |=> (cnt_fc == $past(cnt_fc));
   endproperty
   a_fc_end: assert property (p_fc_end) else $error("false carrier counted mid event");

   property p_keep;
      @(posedge sys_clk) disable iff (sys_rst)
      (rd_re & inc_re) |=> (cnt_re == 16'h0001);
   endproperty
   a_keep: assert property (p_keep) else $error("event lost on clearing read");

   property p_load;
      @(posedge sys_clk) disable iff (sys_rst)
      st_ff.load |=> (scr_out.load & ~st_ff.load) ##1 ~scr_out.load;
   endproperty
   a_load: assert property (p_load) else $error("load bit did not self clear");

   property p_compat;
      @(posedge sys_clk) disable iff (sys_rst)
      st_ff.cfg[`PSC_BIT_CFG_COMPAT] |=> $stable(st_ff.key);
   endproperty
   a_compat: assert property (p_compat) else $error("key changed in compat mode");

   property p_msb;
      @(posedge sys_clk) disable iff (sys_rst)
      $rose(cnt_re[15]) |-> st_ff.status[`PSC_BIT_RXERR_MSB];
   endproperty
   a_msb: assert property (p_msb) else $error("rx error msb flag not set");

   property p_bypass;
      @(posedge sys_clk) disable iff (sys_rst)
      (st_ff.key == 11'h000) |=> scr_out.bypass;
   endproperty
   a_bypass: assert property (p_bypass) else $error("zero key not bypassed");

   property p_page;
      @(posedge sys_clk) disable iff (sys_rst)
      page_evt |=> st_ff.pg_rx ##1 (~st_ff.pg_rx | $past(page_evt));
   endproperty
   a_page: assert property (p_page) else $error("page flag not self clearing");

   property p_pg_next;
      @(posedge sys_clk) disable iff (sys_rst)
      (page_evt & st_ff.pg_seen & ~inc_ll) |=> (page_is_next == 1'b1);
   endproperty
   a_pg_next: assert property (p_pg_next) else $error("later page not marked as next");

   property p_rf_aneg;
      @(posedge sys_clk) disable iff (sys_rst)
      (st_ff.cfg[`PSC_BIT_CFG_ANEG] & page_evt & aneg_in.remote_fault) |=> st_ff.status[`PSC_BIT_REMOTE_FAULT];
   endproperty
   a_rf_aneg: assert property (p_rf_aneg) else $error("partner remote fault not flagged");

   property p_far_fault;
      @(posedge sys_clk) disable iff (sys_rst)
      (~st_ff.cfg[`PSC_BIT_CFG_ANEG] & evt_s.far_end_fault) |=> st_ff.status[`PSC_BIT_REMOTE_FAULT];
   endproperty
   a_far_fault: assert property (p_far_fault) else $error("far end fault not flagged");
endmodule
`default_nettype wire

//--- verif/psc_mgmt_model.sv
// Management-side APB master model that issues register transfers
`timescale 1ns/1ps
`default_nettype none
module psc_mgmt_model (
   input wire logic sys_clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // Bus idles from time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
   end

   // One transfer, entered right after a rising edge; request held until pready
   // A dead slave is caught by the bench watchdog, not here
   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Gap cycle so no strobe is assigned twice in one step
      @(posedge sys_clk);
   endtask
endmodule
`default_nettype wire

//--- verif/phy_status_counters_scrambler_key_test.sv
// Self-checking bench for the PHY status, counter and scrambler seed bank
`timescale 1ns/1ps
`default_nettype none
`include "psc_map.svh"
module phy_status_counters_scrambler_key_test;
   logic sys_clk;
   logic sys_rst;
   logic psel, penable, pwrite, pready, pslverr, page_is_next, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   psc_pkg::psc_evt_s evt; // Datapath event levels
   psc_pkg::psc_aneg_s aneg; // Negotiation word strobes
   psc_pkg::psc_scr_s scr;
   int fail_count = 0;
   int num_checks = 0;
   int loads = 0; // Seed load pulses seen

   psc_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .evt_pins(evt), .aneg_in(aneg), .scr_out(scr),
      .page_is_next(page_is_next), .irq(irq));
   psc_mgmt_model u_mgmt (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   // 100 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // Count single-cycle load pulses, which the tasks cannot catch in flight
   always @(posedge sys_clk) begin
      if (scr.load === 1'b1) begin
         loads++;
      end
   end

   // Compare a register value or count
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   // Compare a single flag
   task automatic chk_pin(input logic got, input logic exp);
      chk_reg({31'h0, got}, {31'h0, exp});
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] v;
      logic e;
      u_mgmt.xfer(1'b1, idx, d, v, e);
   endtask

   task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] v;
      logic e;
      u_mgmt.xfer(1'b0, idx, 32'h0, v, e);
      chk_reg(v, exp);
   endtask

   task automatic wait_n(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // One packet; the error and collision levels outlast the packet end
   task automatic pkt(input logic err, input logic col);
      evt.rx_packet_active <= 1'b1;
      evt.rx_error <= err;
      evt.collision <= col;
      wait_n(6);
      evt.rx_packet_active <= 1'b0;
      wait_n(6);
      evt.rx_error <= 1'b0;
      evt.collision <= 1'b0;
      wait_n(2);
   endtask

   // One checked negotiation word
   task automatic aword(input logic rf);
      aneg <= '{word_valid: 1'b1, word_checked: 1'b1, remote_fault: rf};
      @(posedge sys_clk);
      aneg <= '0;
      wait_n(3);
   endtask

   task automatic end_sim;
      $display("checks %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Watchdog: the sequence needs well under 2000 cycles
   initial begin
      wait_n(20000);
      fail_count++;
      end_sim();
   end

   initial begin
      logic [31:0] v;
      logic e;
      sys_rst = 1'b1;
      evt = '0;
      evt.link_good = 1'b1;
      aneg = '0;
      wait_n(2);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      chk_pin(scr.bypass, 1'b1);
      rd_chk(`PSC_IDX_SCR_SEED, 32'h0);
      // Three link drops, then clear on read
      repeat (3) begin
         evt.link_good <= 1'b0;
         wait_n(6);
         evt.link_good <= 1'b1;
         wait_n(6);
      end
      rd_chk(`PSC_IDX_LINK_LOSS, 32'h3);
      rd_chk(`PSC_IDX_LINK_LOSS, 32'h0);
      // A long false carrier counts once, only at its end
      evt.false_carrier <= 1'b1;
      wait_n(20);
      rd_chk(`PSC_IDX_FALSE_CAR, 32'h0);
      evt.false_carrier <= 1'b0;
      wait_n(6);
      rd_chk(`PSC_IDX_FALSE_CAR, 32'h1);
      rd_chk(`PSC_IDX_FALSE_CAR, 32'h0);
      // Errored packets count unless a collision caused them
      pkt(1'b1, 1'b0);
      pkt(1'b1, 1'b0);
      pkt(1'b1, 1'b1);
      pkt(1'b0, 1'b0);
      rd_chk(`PSC_IDX_RX_ERR, 32'h2);
      rd_chk(`PSC_IDX_RX_ERR, 32'h0);
      // Packet end lands on the clearing read; the count survives it
      evt.rx_packet_active <= 1'b1;
      evt.rx_error <= 1'b1;
      wait_n(6);
      evt.rx_packet_active <= 1'b0;
      @(posedge sys_clk);
      rd_chk(`PSC_IDX_RX_ERR, 32'h0);
      evt.rx_error <= 1'b0;
      rd_chk(`PSC_IDX_RX_ERR, 32'h1);
      // Seed load with reserved bits written as zero
      wr(`PSC_IDX_SCR_SEED, 32'h0000_8123);
      wait_n(1);
      chk_reg(loads, 32'h1);
      chk_reg({21'h0, scr.key}, 32'h123);
      chk_pin(scr.bypass, 1'b0);
      rd_chk(`PSC_IDX_SCR_SEED, 32'h123);
      // Compatibility mode ignores key writes
      wr(`PSC_IDX_CONFIG, 32'h3);
      wr(`PSC_IDX_SCR_SEED, 32'h0000_0055);
      rd_chk(`PSC_IDX_SCR_SEED, 32'h123);
      wr(`PSC_IDX_CONFIG, 32'h1);
      wr(`PSC_IDX_SCR_SEED, 32'h0);
      chk_pin(scr.bypass, 1'b1);
      // Partner remote fault with negotiation on; page kinds
      wr(`PSC_IDX_IRQ_ENABLE, 32'h4);
      aword(1'b1);
      chk_pin(irq, 1'b1);
      chk_pin(page_is_next, 1'b0);
      aword(1'b0);
      chk_pin(page_is_next, 1'b1);
      rd_chk(`PSC_IDX_INT_STATUS, 32'h4);
      wr(`PSC_IDX_IRQ_CLEAR, 32'h4);
      chk_pin(irq, 1'b0);
      rd_chk(`PSC_IDX_INT_STATUS, 32'h0);
      // Far-end fault with negotiation off
      wr(`PSC_IDX_CONFIG, 32'h0);
      evt.far_end_fault <= 1'b1;
      wait_n(6);
      evt.far_end_fault <= 1'b0;
      wait_n(6);
      rd_chk(`PSC_IDX_INT_STATUS, 32'h4);
      // Unmapped index is refused with an error and zero data
      u_mgmt.xfer(1'b0, 8'h30, 32'h0, v, e);
      chk_pin(e, 1'b1);
      chk_reg(v, 32'h0);
      end_sim();
   end
endmodule
`default_nettype wire
